// ===== src/sfp_pkg.sv
// Constants for the servo feedback pulse output block.
// Assumes one 50 MHz clock and a 16-bit register port with one-cycle read latency.
package sfp_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned MODE_W = 9;
  localparam int unsigned TRQ_W = 12;
  localparam int unsigned CODE_W = 5;
  localparam int unsigned IRQ_W = 3;

  // Register indices
  localparam logic [3:0] REG_MODE = 4'h0;
  localparam logic [3:0] REG_NUM = 4'h1;
  localparam logic [3:0] REG_DEN = 4'h2;
  localparam logic [3:0] REG_FLAG_CODE = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_IRQ_STATUS = 4'h5;
  localparam logic [3:0] REG_IRQ_ENABLE = 4'h6;
  localparam logic [3:0] REG_IRQ_CLEAR = 4'h7;

  // Reset values, the mode limit and the flag codes
  localparam logic [8:0] MODE_RESET = 9'h001;
  localparam logic [8:0] MODE_MAX = 9'h100;
  localparam logic [15:0] NUM_RESET = 16'h2710;
  localparam logic [15:0] DEN_RESET = 16'hFFFF;
  localparam logic [4:0] CODE_REACHED_CLOSED = 5'h0F;
  localparam logic [4:0] CODE_REACHED_OPEN = 5'h10;

  // Mode fields
  localparam int unsigned MODE_SRC_LSB = 0;
  localparam int unsigned MODE_SRC_MSB = 1;
  localparam int unsigned MODE_PHASE_BIT = 2;
  localparam int unsigned MODE_ZPOL_BIT = 3;
  localparam logic [1:0] SRC_MOTOR_ENCODER = 2'h1;

  // Interrupt event bits
  localparam int unsigned EV_TORQUE = 0;
  localparam int unsigned EV_INDEX = 1;
  localparam int unsigned EV_SATURATE = 2;

  // Status register bits
  localparam int unsigned ST_REACHED = 0;
  localparam int unsigned ST_ACTIVE = 1;
  localparam int unsigned ST_QUAD_LSB = 2;

  // Output timing: least spacing between quadrature edges and index width
  localparam int unsigned EDGE_NS = 200;
  localparam int unsigned EDGE_CYCLES = (EDGE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned INDEX_NS = 1000;
  localparam int unsigned INDEX_CYCLES = (INDEX_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  typedef enum logic [1:0] {
    SFP_Q0 = 2'b00,
    SFP_Q1 = 2'b01,
    SFP_Q2 = 2'b11,
    SFP_Q3 = 2'b10
  } sfp_quad_type;
endpackage

// ===== src/sfp_top.sv
// Servo feedback pulse output: torque-reached contact and scaled A/B/Z encoder re-emitter.
// Assumes all inputs are synchronous to ref_clk; encoder counts arrive as one-cycle step pulses.
//
// The address map and the strobed register port are this design's own decisions.
module sfp_top #(
  parameter int unsigned ACC_W = 20,
  parameter int unsigned EDGE_CYC = sfp_pkg::EDGE_CYCLES,
  parameter int unsigned INDEX_CYC = sfp_pkg::INDEX_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Register port
  input wire logic [sfp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [sfp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [sfp_pkg::DATA_W-1:0] reg_rdata,
  // Torque measurement and limits
  input wire logic [sfp_pkg::TRQ_W-1:0] torque_mag,
  input wire logic motor_dir_fwd,
  input wire logic [sfp_pkg::TRQ_W-1:0] fwd_torque_limit,
  input wire logic [sfp_pkg::TRQ_W-1:0] rev_torque_limit,
  // Motor encoder
  input wire logic enc_step,
  input wire logic enc_dir_fwd,
  input wire logic enc_index,
  // Outputs
  output logic torque_reached_flag,
  output logic phase_a_out_pos,
  output logic phase_a_out_neg,
  output logic phase_b_out_pos,
  output logic phase_b_out_neg,
  output logic index_out_pos,
  output logic index_out_neg,
  output logic irq
);

  localparam logic [sfp_pkg::IRQ_W-1:0] IRQ_ZERO = '0;
  localparam logic signed [ACC_W-1:0] ACC_ZERO = '0;
  localparam logic signed [ACC_W-1:0] ACC_MAX = {1'b0, {(ACC_W-1){1'b1}}};
  localparam logic signed [ACC_W-1:0] ACC_MIN = -ACC_MAX;
  // One bit wider and signed, so the saturation compare stays signed on both sides
  localparam logic signed [ACC_W:0] ACC_MAX_W = {ACC_MAX[ACC_W-1], ACC_MAX};
  localparam logic signed [ACC_W:0] ACC_MIN_W = {ACC_MIN[ACC_W-1], ACC_MIN};
  localparam int unsigned EW = $clog2(EDGE_CYC + 1);
  localparam int unsigned ZW = $clog2(INDEX_CYC + 1);
  localparam logic [EW-1:0] EDGE_LOAD = EW'(EDGE_CYC - 1);
  localparam logic [ZW-1:0] INDEX_LOAD = ZW'(INDEX_CYC);

  // Registers
  logic [sfp_pkg::MODE_W-1:0] pulse_output_mode;
  logic [15:0] pulse_ratio_numerator;
  logic [15:0] pulse_ratio_denominator;
  logic [sfp_pkg::CODE_W-1:0] flag_code;
  logic [sfp_pkg::IRQ_W-1:0] irq_status;
  logic [sfp_pkg::IRQ_W-1:0] irq_enable;

  // Datapath state
  logic signed [ACC_W-1:0] acc;
  sfp_pkg::sfp_quad_type quad;
  logic [EW-1:0] edge_cnt;
  logic [ZW-1:0] index_cnt;
  logic reached_q;

  // Register decode
  wire wr_mode = reg_wr && (reg_addr == sfp_pkg::REG_MODE);
  wire wr_num = reg_wr && (reg_addr == sfp_pkg::REG_NUM);
  wire wr_den = reg_wr && (reg_addr == sfp_pkg::REG_DEN);
  wire wr_code = reg_wr && (reg_addr == sfp_pkg::REG_FLAG_CODE);
  wire wr_ien = reg_wr && (reg_addr == sfp_pkg::REG_IRQ_ENABLE);
  wire wr_iclr = reg_wr && (reg_addr == sfp_pkg::REG_IRQ_CLEAR);

  // Values above 256 are clamped rather than wrapped into low bits
  wire mode_over = reg_wdata > 16'(sfp_pkg::MODE_MAX);
  wire [sfp_pkg::MODE_W-1:0] mode_wval = mode_over ? sfp_pkg::MODE_MAX :
                                         reg_wdata[sfp_pkg::MODE_W-1:0];

  // Mode fields
  wire [1:0] mode_src = pulse_output_mode[sfp_pkg::MODE_SRC_MSB:sfp_pkg::MODE_SRC_LSB];
  wire src_active = (mode_src == sfp_pkg::SRC_MOTOR_ENCODER);
  wire b_leads = pulse_output_mode[sfp_pkg::MODE_PHASE_BIT];
  wire z_negative = pulse_output_mode[sfp_pkg::MODE_ZPOL_BIT];

  // Torque comparison against the limit of the present direction
  wire [sfp_pkg::TRQ_W-1:0] active_limit = motor_dir_fwd ? fwd_torque_limit : rev_torque_limit;
  wire reached = torque_mag >= active_limit;
  // Any code other than 16 behaves as 15, so the contact is never left undefined
  wire contact_closed = (flag_code == sfp_pkg::CODE_REACHED_OPEN) ? !reached : reached;

  // Scaling accumulator: each encoder count adds the numerator, each output count removes the denominator
  wire signed [ACC_W-1:0] num_s = ACC_W'($signed({1'b0, pulse_ratio_numerator}));
  wire signed [ACC_W-1:0] den_s = ACC_W'($signed({1'b0, pulse_ratio_denominator}));
  wire den_zero = (pulse_ratio_denominator == 16'h0000);
  wire edge_ok = (edge_cnt == '0);
  wire step_fwd = src_active && !den_zero && edge_ok && (acc >= den_s);
  wire step_rev = src_active && !den_zero && edge_ok && (acc <= -den_s);
  wire step_any = step_fwd || step_rev;
  wire signed [ACC_W-1:0] acc_in = (enc_step && src_active) ? (enc_dir_fwd ? num_s : -num_s) : ACC_ZERO;
  wire signed [ACC_W-1:0] acc_out = step_fwd ? den_s : (step_rev ? -den_s : ACC_ZERO);
  wire signed [ACC_W:0] acc_sum = {acc[ACC_W-1], acc} + {acc_in[ACC_W-1], acc_in} -
                                  {acc_out[ACC_W-1], acc_out};
  // Saturation loses counts instead of wrapping, which would reverse the reported motion
  wire acc_hi = acc_sum > ACC_MAX_W;
  wire acc_lo = acc_sum < ACC_MIN_W;
  wire signed [ACC_W-1:0] next_acc = !src_active ? ACC_ZERO :
                                     acc_hi ? ACC_MAX :
                                     acc_lo ? ACC_MIN : acc_sum[ACC_W-1:0];

  // One quadrature step per output count, Gray sequence so no state is skipped
  sfp_pkg::sfp_quad_type next_quad;
  always_comb begin
    next_quad = quad;
    if (step_any) begin
      case (quad)
        sfp_pkg::SFP_Q0: begin
          next_quad = step_fwd ? sfp_pkg::SFP_Q1 : sfp_pkg::SFP_Q3;
        end
        sfp_pkg::SFP_Q1: begin
          next_quad = step_fwd ? sfp_pkg::SFP_Q2 : sfp_pkg::SFP_Q0;
        end
        sfp_pkg::SFP_Q2: begin
          next_quad = step_fwd ? sfp_pkg::SFP_Q3 : sfp_pkg::SFP_Q1;
        end
        sfp_pkg::SFP_Q3: begin
          next_quad = step_fwd ? sfp_pkg::SFP_Q0 : sfp_pkg::SFP_Q2;
        end
        default: begin
          next_quad = sfp_pkg::SFP_Q0;
        end
      endcase
    end
  end

  // In the sequence 00,01,11,10 bit 1 lags bit 0 by a quarter cycle going forward
  wire lead_ph = next_quad[0];
  wire lag_ph = next_quad[1];
  wire next_a = src_active && (b_leads ? lag_ph : lead_ph);
  wire next_b = src_active && (b_leads ? lead_ph : lag_ph);
  wire index_fire = src_active && enc_index;
  wire z_active = index_fire || (index_cnt != '0);
  wire next_z = z_active ^ z_negative;

  wire [ZW-1:0] next_index_cnt = index_fire ? INDEX_LOAD :
                                 (index_cnt != '0) ? index_cnt - ZW'(1) : '0;
  wire [EW-1:0] next_edge_cnt = step_any ? EDGE_LOAD :
                                edge_ok ? edge_cnt : edge_cnt - EW'(1);

  // Interrupt events; a new event outweighs a clear in the same cycle
  wire [sfp_pkg::IRQ_W-1:0] events = {acc_hi || acc_lo, index_fire, reached && !reached_q};
  wire [sfp_pkg::IRQ_W-1:0] clr_mask = wr_iclr ? reg_wdata[sfp_pkg::IRQ_W-1:0] : IRQ_ZERO;
  wire [sfp_pkg::IRQ_W-1:0] next_irq_status = (irq_status & ~clr_mask) | events;
  wire next_irq = |(next_irq_status & (wr_ien ? reg_wdata[sfp_pkg::IRQ_W-1:0] : irq_enable));

  // Read mux; the clear register is write-only and reads as zero
  wire [15:0] status_word = {12'h000, quad, src_active, reached};
  logic [15:0] rd_mux;
  always_comb begin
    case (reg_addr)
      sfp_pkg::REG_MODE: rd_mux = 16'(pulse_output_mode);
      sfp_pkg::REG_NUM: rd_mux = pulse_ratio_numerator;
      sfp_pkg::REG_DEN: rd_mux = pulse_ratio_denominator;
      sfp_pkg::REG_FLAG_CODE: rd_mux = 16'(flag_code);
      sfp_pkg::REG_STATUS: rd_mux = status_word;
      sfp_pkg::REG_IRQ_STATUS: rd_mux = 16'(irq_status);
      sfp_pkg::REG_IRQ_ENABLE: rd_mux = 16'(irq_enable);
      default: rd_mux = 16'h0000;
    endcase
  end

  // Configuration registers, one short process per register
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pulse_output_mode <= sfp_pkg::MODE_RESET;
    end else if (wr_mode) begin
      pulse_output_mode <= mode_wval;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pulse_ratio_numerator <= sfp_pkg::NUM_RESET;
    end else if (wr_num) begin
      pulse_ratio_numerator <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pulse_ratio_denominator <= sfp_pkg::DEN_RESET;
    end else if (wr_den) begin
      pulse_ratio_denominator <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      flag_code <= sfp_pkg::CODE_REACHED_CLOSED;
    end else if (wr_code) begin
      flag_code <= reg_wdata[sfp_pkg::CODE_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      irq_enable <= IRQ_ZERO;
    end else if (wr_ien) begin
      irq_enable <= reg_wdata[sfp_pkg::IRQ_W-1:0];
    end
  end

  // Read data and interrupt state
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      irq_status <= IRQ_ZERO;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // Divider and quadrature state
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      acc <= ACC_ZERO;
    end else begin
      acc <= next_acc;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      quad <= sfp_pkg::SFP_Q0;
    end else begin
      quad <= next_quad;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      edge_cnt <= '0;
    end else begin
      edge_cnt <= next_edge_cnt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      index_cnt <= '0;
    end else begin
      index_cnt <= next_index_cnt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      reached_q <= 1'b0;
    end else begin
      reached_q <= reached;
    end
  end

  // Output pins; both halves of a pair load from one next value, so the pair never skews by a cycle
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      torque_reached_flag <= 1'b0;
    end else begin
      torque_reached_flag <= contact_closed;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      phase_a_out_pos <= 1'b0;
    end else begin
      phase_a_out_pos <= next_a;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      phase_a_out_neg <= 1'b1;
    end else begin
      phase_a_out_neg <= !next_a;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      phase_b_out_pos <= 1'b0;
    end else begin
      phase_b_out_pos <= next_b;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      phase_b_out_neg <= 1'b1;
    end else begin
      phase_b_out_neg <= !next_b;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      index_out_pos <= 1'b0;
    end else begin
      index_out_pos <= next_z;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      index_out_neg <= 1'b1;
    end else begin
      index_out_neg <= !next_z;
    end
  end

endmodule // sfp_top

// ===== bench/sfp_ctrl_model.sv
// Partner model: motion controller decoding the differential A/B feedback into a position count.
// Assumes A is state bit 0 and B bit 1 of the forward sequence 00, 01, 11, 10.
module sfp_ctrl_model (
  // Clock
  input wire logic ref_clk,
  // Feedback pairs
  input wire logic a_pos,
  input wire logic a_neg,
  input wire logic b_pos,
  input wire logic b_neg,
  // Decoded position
  output int pos
);
  int cnt = 0;
  logic [1:0] last = 2'h0;
  // A pair that is not complementary reads as low
  wire logic a = a_pos & !a_neg;
  wire logic b = b_pos & !b_neg;
  // Gray to binary, so one subtraction gives the direction
  wire logic [1:0] cur = {b, a ^ b};
  assign pos = cnt;
  always @(posedge ref_clk) begin
    if (cur - last == 2'h1) cnt <= cnt + 1;
    else if (cur - last == 2'h3) cnt <= cnt - 1;
    last <= cur;
  end
endmodule // sfp_ctrl_model

// ===== bench/sfp_top_chk.sv
// Checker for sfp_top port timing: flag, quadrature pairs and index.
// Assumes INDEX_CYC of at least 2 and no mode change inside an index pulse.
module sfp_top_chk #(
  parameter int unsigned INDEX_CYC = 2
) (
  // Clock, reset, register port
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Torque and encoder
  input wire logic [11:0] torque_mag,
  input wire logic motor_dir_fwd,
  input wire logic [11:0] fwd_torque_limit,
  input wire logic [11:0] rev_torque_limit,
  input wire logic enc_index,
  // Outputs
  input wire logic torque_reached_flag,
  input wire logic phase_a_out_pos,
  input wire logic phase_a_out_neg,
  input wire logic phase_b_out_pos,
  input wire logic phase_b_out_neg,
  input wire logic index_out_pos,
  input wire logic index_out_neg
);
  logic [8:0] mode_q;
  logic [15:0] den_q;
  logic [4:0] code_q;
  wire logic src_on = mode_q[1:0] == 2'h1;
  wire logic reached = torque_mag >= (motor_dir_fwd ? fwd_torque_limit : rev_torque_limit);
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mode_q <= 9'h001;
      den_q <= 16'hFFFF;
      code_q <= 5'h0F;
    end else if (reg_wr) begin
      if (reg_addr == 4'h0) mode_q <= (reg_wdata > 16'h0100) ? 9'h100 : reg_wdata[8:0];
      if (reg_addr == 4'h2) den_q <= reg_wdata;
      if (reg_addr == 4'h3) code_q <= reg_wdata[4:0];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_diff_pairs:
    assert property (phase_a_out_neg == !phase_a_out_pos && phase_b_out_neg == !phase_b_out_pos
      && index_out_neg == !index_out_pos) else $error("output pair not complementary");
  a_flag_polarity:
    assert property ($past(resetn, 2) && $past(resetn) |-> torque_reached_flag ==
      (($past(code_q) == 5'h10) ^ $past(reached))) else $error("torque flag wrong");
  a_mode_readback:
    assert property ($past(reg_rd) && $past(reg_addr) == 4'h0 |-> reg_rdata == {7'h00, $past(mode_q)})
      else $error("mode read back wrong");
  a_single_step:
    assert property ($past(resetn, 2) && $past(mode_q) == $past(mode_q, 2) && $past(mode_q[1:0]) == 2'h1
      |-> !($changed(phase_a_out_pos) && $changed(phase_b_out_pos))) else $error("quadrature skipped a step");
  a_source_quiet:
    assert property (!src_on && $past(mode_q[1:0]) != 2'h1 |-> !phase_a_out_pos && !phase_b_out_pos)
      else $error("pulses without encoder source");
  a_index_idle:
    assert property (!src_on && $past(mode_q[1:0]) != 2'h1 |-> index_out_pos == $past(mode_q[3]))
      else $error("index idle level wrong");
  a_den_zero:
    assert property (den_q == 16'h0000 && $past(den_q) == 16'h0000 && src_on && $past(src_on)
      |-> $stable(phase_a_out_pos) && $stable(phase_b_out_pos)) else $error("step with zero denominator");
  a_index_pulse:
    assert property (enc_index && src_on |=> (index_out_pos != mode_q[3]) [*2])
      else $error("index pulse missing or short");
endmodule // sfp_top_chk
bind sfp_top sfp_top_chk #(.INDEX_CYC(INDEX_CYC)) u_chk (.*);

// ===== bench/servo_feedback_pulse_out_tb.sv
// Testbench for sfp_top: registers, torque flag, irq, scaled quadrature and index.
// Assumes the bound checker and the controller model beside the design.
module servo_feedback_pulse_out_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'h0, resetn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, motor_dir_fwd = 1'h0;
  logic enc_step = 1'h0, enc_dir_fwd = 1'h1, enc_index = 1'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, rv;
  logic [11:0] torque_mag = 12'h000, fwd_torque_limit = 12'h000, rev_torque_limit = 12'h000;
  logic torque_reached_flag, phase_a_out_pos, phase_a_out_neg, phase_b_out_pos, phase_b_out_neg;
  logic index_out_pos, index_out_neg, irq;
  int n_errors = 0, checks = 0, pos, p0, e;
  // Short edge spacing and index width keep the run brief
  sfp_top #(.EDGE_CYC(1), .INDEX_CYC(2)) u_dut (.*);
  sfp_ctrl_model u_ctrl (.ref_clk(ref_clk), .a_pos(phase_a_out_pos), .a_neg(phase_a_out_neg),
    .b_pos(phase_b_out_pos), .b_neg(phase_b_out_neg), .pos(pos));
  initial forever #10 ref_clk = !ref_clk;
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
    // A spare edge, so a following write never lowers and raises the strobe in one step
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    @(posedge ref_clk);
    v = reg_rdata;
  endtask
  // Steps are four cycles apart, wider than the output edge spacing
  task automatic step(input logic f, input int n);
    repeat (n) begin
      enc_step <= 1'h1;
      enc_dir_fwd <= f;
      @(posedge ref_clk);
      enc_step <= 1'h0;
      repeat (3) @(posedge ref_clk);
    end
  endtask
  function automatic logic exp_flag(input logic [4:0] c);
    logic r;
    r = torque_mag >= (motor_dir_fwd ? fwd_torque_limit : rev_torque_limit);
    return (c == 5'h10) ? !r : r;
  endfunction
  task automatic print_verdict;
    $display("counts: %0d checks, %0d errors", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_errors++;
    print_verdict();
  end
  initial begin
    logic [11:0] t;
    logic d;
    void'($urandom(60));
    repeat (16) @(posedge ref_clk);
    resetn <= 1'h1;
    @(posedge ref_clk);
    rd(4'h0, rv);
    chk("mode", rv, 16'h0001);
    rd(4'h1, rv);
    chk("numerator", rv, 16'h2710);
    rd(4'h2, rv);
    chk("denominator", rv, 16'hFFFF);
    wr(4'h0, 16'h0201);
    rd(4'h0, rv);
    chk("mode clamp", rv, 16'h0100);
    rd(4'h8, rv);
    chk("unmapped", rv, 16'h0000);
    $display("test registers done");
    wr(4'h6, 16'h0001);
    for (int i = 0; i < 40; i++) begin
      if (i == 20) wr(4'h3, 16'h0010);
      t = 12'($urandom);
      torque_mag <= t;
      fwd_torque_limit <= (i % 4 == 0) ? t : 12'($urandom);
      rev_torque_limit <= (i % 4 == 1) ? t : 12'($urandom);
      motor_dir_fwd <= 1'($urandom);
      repeat (2) @(posedge ref_clk);
      chk("flag", torque_reached_flag, exp_flag(i < 20 ? 5'h0F : 5'h10));
    end
    torque_mag <= 12'h000;
    fwd_torque_limit <= 12'h800;
    rev_torque_limit <= 12'h800;
    repeat (3) @(posedge ref_clk);
    wr(4'h7, 16'h0007);
    @(posedge ref_clk);
    chk("irq idle", irq, 16'h0000);
    torque_mag <= 12'hFFF;
    repeat (3) @(posedge ref_clk);
    chk("irq raised", irq, 16'h0001);
    wr(4'h6, 16'h0000);
    @(posedge ref_clk);
    chk("irq masked", irq, 16'h0000);
    wr(4'h6, 16'h0001);
    wr(4'h7, 16'h0001);
    @(posedge ref_clk);
    chk("irq cleared", irq, 16'h0000);
    $display("test torque flag done");
    wr(4'h0, 16'h0001);
    wr(4'h2, 16'h0001);
    wr(4'h1, 16'h0001);
    p0 = pos;
    e = 0;
    repeat (24) begin
      d = 1'($urandom);
      e += d ? 1 : -1;
      step(d, 1);
    end
    repeat (4) @(posedge ref_clk);
    chk("net steps", 16'(pos - p0), 16'(e));
    wr(4'h2, 16'h0003);
    p0 = pos;
    step(1'h1, 30);
    chk("divided steps", 16'(pos - p0), 16'h000A);
    wr(4'h2, 16'h0000);
    p0 = pos;
    step(1'h1, 4);
    chk("zero denominator", 16'(pos - p0), 16'h0000);
    wr(4'h0, 16'h0000);
    wr(4'h2, 16'h0001);
    wr(4'h0, 16'h0005);
    // Re-enabling the source makes the pins jump; let the model take that before counting
    repeat (3) @(posedge ref_clk);
    p0 = pos;
    step(1'h1, 3);
    chk("b leads a", 16'(pos - p0), 16'hFFFD);
    wr(4'h0, 16'h0002);
    repeat (2) @(posedge ref_clk);
    chk("source off", {phase_a_out_pos, phase_b_out_pos}, 16'h0000);
    $display("test quadrature done");
    for (int k = 0; k < 2; k++) begin
      wr(4'h0, k ? 16'h0009 : 16'h0001);
      repeat (2) @(posedge ref_clk);
      chk("z idle", index_out_pos, 16'(k));
      enc_index <= 1'h1;
      @(posedge ref_clk);
      enc_index <= 1'h0;
      @(posedge ref_clk);
      chk("z active", index_out_pos, 16'(k == 0));
      repeat (6) @(posedge ref_clk);
    end
    rd(4'h5, rv);
    chk("irq status", rv, 16'h0002);
    $display("test index done");
    print_verdict();
  end
endmodule // servo_feedback_pulse_out_tb
